// [rtl/shs_pkg.sv]
// Constants and types shared by the homing sequencer files
//
// Behaviour
// - Seeing both limit switches active in one homing run is a homing error.
// - Negative limit active under methods 2, 7-10, 23-26 is a homing error.
// - Positive limit active under methods 1, 11-14, 27-30 is a homing error.
// - Any limit active under methods 3, 4, 19, 20 is a homing error.
// - Any limit or homing switch active under methods 33, 34 is an error.
// - Start edge with absolute encoder fitted is a homing error.
// - On error set state word bit 13 and stop the motor at once.
// - Methods -6/-5 creep neg/pos, stop on torque, done after delay.
// - Methods -4/-3 fast, reverse on torque, stop when gone, done after delay.
// - Methods -2/-1 fast, reverse on torque, stop at index after torque gone.
// - Method 1 off limit: fast negative to limit, slow positive to index.
// - Method 1 on limit: leave positive fast, fast back, then slow search.
// - Method 2 off limit: fast positive to limit, slow negative to index.
// - Method 2 on limit: leave negative fast, fast back, then slow search.
// - Method 3 off switch: fast positive to switch, slow negative past it.
// - Methods 3/4 on switch: first leave negative fast past the switch.
// - Method 4: fast on, fast off, slow positive to index on switch.
// - Method 5: seek switch negative fast, finish slow positive past it.
// - Method 6: fast on, fast off, slow negative to index on switch.
// - Homing done bit 12 set only after target reached.
package shs_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int CMD_HOME_START_BIT = 4;
  localparam int ST_TARGET_BIT      = 10;
  localparam int ST_DONE_BIT        = 12;
  localparam int ST_ERROR_BIT       = 13;
  localparam int WORD_W             = 16;
  localparam int METHOD_W           = 8;
  localparam int TORQUE_W           = 16;
  localparam int DELAY_W            = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 20;
  localparam int DELAY_UNIT_NS     = 1000000;
  localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Synchronised pin positions
  // ----------------------------------------------------------------
  localparam int PIN_START = 0;
  localparam int PIN_POS   = 1;
  localparam int PIN_NEG   = 2;
  localparam int PIN_HOME  = 3;
  localparam int PIN_INDEX = 4;
  localparam int PIN_COUNT = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    S_IDLE  = 10'h001,
    S_TORQ  = 10'h002,
    S_TBACK = 10'h004,
    S_SEEK  = 10'h008,
    S_LEAVE = 10'h010,
    S_SLOW  = 10'h020,
    S_TGT   = 10'h040,
    S_DELAY = 10'h080,
    S_DONE  = 10'h100,
    S_ERR   = 10'h200
  } shs_state_t;

  typedef enum logic [2:0] {
    C_NONE   = 3'h0,
    C_TSTOP  = 3'h1,
    C_TBACK  = 3'h2,
    C_TIDX   = 3'h3,
    C_BEYOND = 3'h4,
    C_ONSW   = 3'h5
  } shs_class_t;

endpackage

// [rtl/shs_pins_if.sv]
// Raw and synchronised switch pins between top and synchroniser
`timescale 1ns/1ps
interface shs_pins_if;
  import shs_pkg::*;
  logic [PIN_COUNT-1:0] raw;
  logic [PIN_COUNT-1:0] synced;
  modport user (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

// [rtl/shs_sync.sv]
// Two-flop synchroniser for the asynchronous switch pins
`timescale 1ns/1ps
module shs_sync (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  shs_pins_if.sync  pins
);
  import shs_pkg::*;

  logic [PIN_COUNT-1:0] meta_r;
  logic [PIN_COUNT-1:0] hold_r;

  // ----------------------------------------------------------------
  // Per-pin stages
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          meta_r[g] <= 1'b0;
          hold_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= pins.raw[g];
          hold_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign pins.synced = hold_r;
endmodule

// [rtl/shs_sequencer.sv]
// Homing sequencer top: method decode, step machine, status bits
`timescale 1ns/1ps
module shs_sequencer #(
  parameter int TICK_CYCLES = shs_pkg::DELAY_UNIT_CYCLES
) (
  input  wire logic                         SYS_CLK_IN,
  input  wire logic                         RST_N_IN,
  input  wire logic [shs_pkg::WORD_W-1:0]   DRIVE_COMMAND_WORD_IN,
  input  wire logic [shs_pkg::METHOD_W-1:0] HOMING_METHOD_IN,
  input  wire logic                         ABS_ENCODER_IN,
  input  wire logic                         POS_LIMIT_IN,
  input  wire logic                         NEG_LIMIT_IN,
  input  wire logic                         HOME_SWITCH_IN,
  input  wire logic                         INDEX_PULSE_IN,
  input  wire logic [shs_pkg::TORQUE_W-1:0] TORQUE_MAG_IN,
  input  wire logic [shs_pkg::TORQUE_W-1:0] HOMING_TORQUE_THRESHOLD_IN,
  input  wire logic [shs_pkg::DELAY_W-1:0]  HOMING_DONE_DELAY_IN,
  input  wire logic                         TARGET_REACHED_IN,
  output logic                              MOVE_EN_OUT,
  output logic                              DIR_POS_OUT,
  output logic                              HIGH_SPEED_OUT,
  output logic                              BUSY_OUT,
  output logic [shs_pkg::WORD_W-1:0]        DRIVE_STATE_WORD_OUT
);
  import shs_pkg::*;

  // Elaboration check: a zero-length tick would never end the delay
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  shs_pins_if pins ();

  assign pins.raw[PIN_START] = DRIVE_COMMAND_WORD_IN[CMD_HOME_START_BIT];
  assign pins.raw[PIN_POS]   = POS_LIMIT_IN;
  assign pins.raw[PIN_NEG]   = NEG_LIMIT_IN;
  assign pins.raw[PIN_HOME]  = HOME_SWITCH_IN;
  assign pins.raw[PIN_INDEX] = INDEX_PULSE_IN;

  shs_sync u_sync (
    .clk_in   (SYS_CLK_IN),
    .rst_n_in (RST_N_IN),
    .pins     (pins.sync)
  );

  logic start_s;
  logic pos_s;
  logic neg_s;
  logic home_s;
  logic index_s;
  assign start_s = pins.synced[PIN_START];
  assign pos_s   = pins.synced[PIN_POS];
  assign neg_s   = pins.synced[PIN_NEG];
  assign home_s  = pins.synced[PIN_HOME];
  assign index_s = pins.synced[PIN_INDEX];

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  logic start_d_r;
  logic index_d_r;
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      start_d_r <= 1'b0;
      index_d_r <= 1'b0;
    end else begin
      start_d_r <= start_s;
      index_d_r <= index_s;
    end
  end

  logic start_rise;
  logic index_rise;
  assign start_rise = start_s && !start_d_r;
  assign index_rise = index_s && !index_d_r;

  // ----------------------------------------------------------------
  // Method decode
  // ----------------------------------------------------------------
  function automatic shs_class_t class_of(input logic signed [7:0] m);
    case (m)
      -8'sd6, -8'sd5: class_of = C_TSTOP;
      -8'sd4, -8'sd3: class_of = C_TBACK;
      -8'sd2, -8'sd1: class_of = C_TIDX;
      8'sd1, 8'sd2, 8'sd3, 8'sd5: class_of = C_BEYOND;
      8'sd4, 8'sd6: class_of = C_ONSW;
      default: class_of = C_NONE;
    endcase
  endfunction

  function automatic logic seek_pos_of(input logic signed [7:0] m);
    case (m)
      -8'sd5, -8'sd3, -8'sd1, 8'sd2, 8'sd3, 8'sd4: seek_pos_of = 1'b1;
      default: seek_pos_of = 1'b0;
    endcase
  endfunction

  function automatic logic in_rng(input logic signed [7:0] m,
                                  input int lo, input int hi);
    in_rng = (int'(m) >= lo) && (int'(m) <= hi);
  endfunction

  logic signed [METHOD_W-1:0] meth_r;
  logic [DELAY_W-1:0]         delay_r;
  logic signed [METHOD_W-1:0] meth;
  shs_class_t                 cls;
  logic                       seek_pos;
  logic                       sw;
  shs_state_t                 state_r;
  shs_state_t                 state_nxt;

  // Decode live input only while idle; latched copy afterwards
  assign meth     = (state_r == S_IDLE) ? HOMING_METHOD_IN : meth_r;
  assign cls      = class_of(meth);
  assign seek_pos = seek_pos_of(meth);
  assign sw       = (meth == 8'sd1) ? neg_s :
                    (meth == 8'sd2) ? pos_s : home_s;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      meth_r  <= '0;
      delay_r <= '0;
    end else if (state_r == S_IDLE && start_rise) begin
      meth_r  <= HOMING_METHOD_IN;
      delay_r <= HOMING_DONE_DELAY_IN;
    end
  end

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  logic seen_pos_r;
  logic seen_neg_r;
  logic running;
  logic torque_hit;
  logic fault;

  assign running = (state_r == S_TORQ) || (state_r == S_TBACK) ||
                   (state_r == S_SEEK) || (state_r == S_LEAVE) ||
                   (state_r == S_SLOW) || (state_r == S_TGT) ||
                   (state_r == S_DELAY);
  assign torque_hit = TORQUE_MAG_IN >= HOMING_TORQUE_THRESHOLD_IN;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      seen_pos_r <= 1'b0;
      seen_neg_r <= 1'b0;
    end else if (state_r == S_IDLE) begin
      seen_pos_r <= 1'b0;
      seen_neg_r <= 1'b0;
    end else if (running) begin
      seen_pos_r <= seen_pos_r || pos_s;
      seen_neg_r <= seen_neg_r || neg_s;
    end
  end

  always_comb begin
    fault = 1'b0;
    if ((seen_pos_r || pos_s) && (seen_neg_r || neg_s)) begin
      fault = 1'b1;
    end
    if (neg_s && (meth == 8'sd2 || in_rng(meth, 7, 10) ||
                  in_rng(meth, 23, 26))) begin
      fault = 1'b1;
    end
    if (pos_s && (meth == 8'sd1 || in_rng(meth, 11, 14) ||
                  in_rng(meth, 27, 30))) begin
      fault = 1'b1;
    end
    if ((pos_s || neg_s) && (in_rng(meth, 3, 4) ||
                             in_rng(meth, 19, 20))) begin
      fault = 1'b1;
    end
    if ((pos_s || neg_s || home_s) && in_rng(meth, 33, 34)) begin
      fault = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Done delay timebase
  // ----------------------------------------------------------------
  logic [31:0]        div_r;
  logic [DELAY_W-1:0] units_r;
  logic               tick;
  assign tick = (div_r == 32'(TICK_CYCLES - 1));

  // Restarted on entry so the delay is never short by a partial unit
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN || state_r != S_DELAY) begin
      div_r   <= '0;
      units_r <= '0;
    end else if (tick) begin
      div_r   <= '0;
      units_r <= units_r + 16'h0001;
    end else begin
      div_r   <= div_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Step machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    if (!start_s) begin
      state_nxt = S_IDLE;
    end else if (running && fault) begin
      state_nxt = S_ERR;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (start_rise) begin
            if (ABS_ENCODER_IN) begin
              state_nxt = S_ERR;
            end else if (cls == C_NONE) begin
              state_nxt = S_ERR;
            end else if (cls == C_TSTOP || cls == C_TBACK ||
                         cls == C_TIDX) begin
              state_nxt = S_TORQ;
            end else if (sw) begin
              state_nxt = S_LEAVE;
            end else begin
              state_nxt = S_SEEK;
            end
          end
        end
        S_TORQ: begin
          if (torque_hit) begin
            state_nxt = (cls == C_TSTOP) ? S_TGT : S_TBACK;
          end
        end
        S_TBACK: begin
          if (!torque_hit) begin
            state_nxt = (cls == C_TBACK) ? S_TGT : S_SLOW;
          end
        end
        S_SEEK: begin
          if (sw) begin
            state_nxt = (cls == C_ONSW) ? S_LEAVE : S_SLOW;
          end
        end
        S_LEAVE: begin
          if (!sw) begin
            state_nxt = (cls == C_ONSW) ? S_SLOW : S_SEEK;
          end
        end
        S_SLOW: begin
          // Index qualified by switch level per method family
          if (index_rise && (cls == C_TIDX ||
                             (cls == C_ONSW && sw) ||
                             (cls == C_BEYOND && !sw))) begin
            state_nxt = S_TGT;
          end
        end
        S_TGT: begin
          if (TARGET_REACHED_IN) begin
            state_nxt = (cls == C_TSTOP || cls == C_TBACK) ?
                        S_DELAY : S_DONE;
          end
        end
        S_DELAY: begin
          if (units_r >= delay_r) begin
            state_nxt = S_DONE;
          end
        end
        S_DONE:  state_nxt = S_DONE;
        S_ERR:   state_nxt = S_ERR;
        default: state_nxt = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Motion command, registered from the next state
  // ----------------------------------------------------------------
  logic move_nxt;
  logic dir_nxt;
  logic fast_nxt;

  always_comb begin
    move_nxt = 1'b1;
    dir_nxt  = seek_pos;
    fast_nxt = 1'b1;
    case (state_nxt)
      S_TORQ:  fast_nxt = (cls != C_TSTOP);
      S_TBACK: begin
        dir_nxt  = !seek_pos;
        fast_nxt = 1'b0;
      end
      S_SEEK:  dir_nxt = seek_pos;
      S_LEAVE: dir_nxt = !seek_pos;
      S_SLOW: begin
        dir_nxt  = (cls == C_ONSW) ? seek_pos : !seek_pos;
        fast_nxt = 1'b0;
      end
      default: begin
        // Idle, done and error all hold the motor still
        move_nxt = 1'b0;
        dir_nxt  = 1'b0;
        fast_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      MOVE_EN_OUT    <= 1'b0;
      DIR_POS_OUT    <= 1'b0;
      HIGH_SPEED_OUT <= 1'b0;
    end else begin
      MOVE_EN_OUT    <= move_nxt;
      DIR_POS_OUT    <= dir_nxt;
      HIGH_SPEED_OUT <= fast_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] word_nxt;
  always_comb begin
    word_nxt = '0;
    word_nxt[ST_TARGET_BIT] = TARGET_REACHED_IN;
    word_nxt[ST_DONE_BIT]   = (state_nxt == S_DONE);
    word_nxt[ST_ERROR_BIT]  = (state_nxt == S_ERR);
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) begin
      DRIVE_STATE_WORD_OUT <= '0;
      BUSY_OUT             <= 1'b0;
    end else begin
      DRIVE_STATE_WORD_OUT <= word_nxt;
      BUSY_OUT             <= (state_nxt != S_IDLE) &&
                              (state_nxt != S_DONE) &&
                              (state_nxt != S_ERR);
    end
  end

endmodule

// [bench/shs_seq_asserts.sv]
// Port-level concurrent checks for the homing sequencer
`timescale 1ns/1ps
module shs_seq_asserts (
  input wire logic                         SYS_CLK_IN,
  input wire logic                         RST_N_IN,
  input wire logic [shs_pkg::WORD_W-1:0]   DRIVE_COMMAND_WORD_IN,
  input wire logic [shs_pkg::METHOD_W-1:0] HOMING_METHOD_IN,
  input wire logic                         ABS_ENCODER_IN,
  input wire logic                         POS_LIMIT_IN,
  input wire logic                         NEG_LIMIT_IN,
  input wire logic                         TARGET_REACHED_IN,
  input wire logic                         MOVE_EN_OUT,
  input wire logic                         DIR_POS_OUT,
  input wire logic                         BUSY_OUT,
  input wire logic [shs_pkg::WORD_W-1:0]   DRIVE_STATE_WORD_OUT
);
  import shs_pkg::*;
  logic go;
  logic done_b;
  logic err_b;
  logic idle_b;
  logic meth_ok;
  assign go      = DRIVE_COMMAND_WORD_IN[CMD_HOME_START_BIT];
  assign done_b  = DRIVE_STATE_WORD_OUT[ST_DONE_BIT];
  assign err_b   = DRIVE_STATE_WORD_OUT[ST_ERROR_BIT];
  assign idle_b  = !BUSY_OUT && !done_b && !err_b;
  assign meth_ok = $signed(HOMING_METHOD_IN) inside {[-6:-1], [1:6]};
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_err_motor_off: assert property (
    err_b |-> !MOVE_EN_OUT && !BUSY_OUT)
    else $error("error flag while motor moving");
  a_err_holds: assert property (err_b && go |=> err_b)
    else $error("error flag dropped with start bit high");
  a_abs_start_err: assert property (
    $rose(go) && ABS_ENCODER_IN && idle_b |-> ##[1:6] err_b && !MOVE_EN_OUT)
    else $error("absolute start no error");
  a_start_moves: assert property (
    $rose(go) && !ABS_ENCODER_IN && meth_ok && idle_b && !POS_LIMIT_IN
    && !NEG_LIMIT_IN |-> ##[2:4] MOVE_EN_OUT && BUSY_OUT)
    else $error("no motion after start edge");
  a_abort_stops: assert property ($fell(go) |-> ##[1:4] !MOVE_EN_OUT
    && !BUSY_OUT) else $error("motor not stopped after abort");
  a_both_limits: assert property (
    BUSY_OUT && POS_LIMIT_IN && NEG_LIMIT_IN |-> ##[1:4] err_b)
    else $error("both limits without error");
  a_done_after_tgt: assert property (
    $rose(done_b) |-> TARGET_REACHED_IN
    && DRIVE_STATE_WORD_OUT[ST_TARGET_BIT]) else $error("done before target");
  a_done_quiet: assert property (done_b |-> !MOVE_EN_OUT && !err_b)
    else $error("done flag while moving or in error");
  a_stop_dir_low: assert property (!MOVE_EN_OUT |-> !DIR_POS_OUT)
    else $error("direction set while stopped");
  a_word_spare: assert property (
    (DRIVE_STATE_WORD_OUT & ~16'h3400) == 16'h0000)
    else $error("unused state word bit set");
  a_clear_on_drop: assert property (!go [*5] |-> !done_b && !err_b)
    else $error("status not cleared with start bit low");
  c_done: cover property ($rose(done_b));
  c_err: cover property ($rose(err_b));
  c_abort: cover property ($fell(go) && BUSY_OUT);
endmodule

// [bench/shs_motor_model.sv]
// Behavioural axis model: position, switches, index pulse, torque
`timescale 1ns/1ps
module shs_motor_model (
  input  wire logic               clk_in,
  input  wire logic               move_en_in,
  input  wire logic               dir_pos_in,
  input  wire logic               high_speed_in,
  input  wire logic               load_in,
  input  wire logic signed [15:0] load_pos_in,
  input  wire logic [1:0]         fault_in,
  output logic                    pos_limit_out,
  output logic                    neg_limit_out,
  output logic                    home_sw_out,
  output logic                    index_out,
  output logic [15:0]             torque_out,
  output logic                    target_out
);
  logic signed [15:0] pos_r;
  logic signed [15:0] pos_nxt;
  logic signed [15:0] step;
  // Hard stops clamp travel so torque methods can press against them
  always_comb begin
    step = high_speed_in ? 16'sh4 : 16'sh1;
    pos_nxt = dir_pos_in ? pos_r + step : pos_r - step;
    if (pos_nxt > 16'sh21c) pos_nxt = 16'sh21c;
    if (pos_nxt < -16'sh21c) pos_nxt = -16'sh21c;
  end
  always_ff @(posedge clk_in) begin
    if (load_in) pos_r <= load_pos_in;
    else if (move_en_in) pos_r <= pos_nxt;
  end
  always_ff @(posedge clk_in) target_out <= !move_en_in;
  assign pos_limit_out = (pos_r >= 16'sh1f4) || fault_in[0];
  assign neg_limit_out = (pos_r <= -16'sh1f4) || fault_in[1];
  assign home_sw_out   = (pos_r >= 16'sh64) && (pos_r <= 16'sh12c);
  // Eight counts wide so a fast pass still holds it two cycles
  assign index_out     = (pos_r[5:3] == 3'h0);
  assign torque_out    = (pos_r >= 16'sh208 || pos_r <= -16'sh208) ?
                         16'h1000 : 16'h0000;
endmodule

// [bench/servo_homing_sequencer_bench.sv]
// Self-checking bench for the homing sequencer
`timescale 1ns/1ps
module servo_homing_sequencer_bench;
  import shs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [WORD_W-1:0] cmd = '0;
  logic [METHOD_W-1:0] meth = '0;
  logic abs_enc = 1'b0;
  logic load = 1'b1;
  logic [1:0] flt = 2'h0;
  logic [TORQUE_W-1:0] thr = 16'h0100;
  logic [DELAY_W-1:0] dly = 16'h0000;
  logic signed [15:0] ld_pos = 16'sh0;
  logic pos_lim, neg_lim, home_sw, idx, tgt, mv, dir, hi, busy;
  logic got_first, f_dir, f_hi, mv_d;
  logic [15:0] trq, word;
  int seed = 28639;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int t_stop = 0;
  int t_done = 0;
  int meths [18] = '{-6,-5,-4,-3,-2,-1,1,1,2,2,3,3,4,4,5,5,6,6};
  int starts [18] = '{0,0,0,0,0,0,0,-510,0,510,0,200,0,200,400,200,400,200};
  bit fdirs [18] = '{0,1,0,1,0,1,0,1,1,0,1,0,1,0,0,1,0,1};
  int fm [6] = '{1,2,3,-6,33,1};
  logic [1:0] ff [6] = '{2'h1,2'h2,2'h2,2'h3,2'h0,2'h0};
  always #10 clk = ~clk;
  shs_sequencer #(.TICK_CYCLES(4)) dut (
    .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .DRIVE_COMMAND_WORD_IN(cmd),
    .HOMING_METHOD_IN(meth), .ABS_ENCODER_IN(abs_enc),
    .POS_LIMIT_IN(pos_lim), .NEG_LIMIT_IN(neg_lim),
    .HOME_SWITCH_IN(home_sw), .INDEX_PULSE_IN(idx), .TORQUE_MAG_IN(trq),
    .HOMING_TORQUE_THRESHOLD_IN(thr), .HOMING_DONE_DELAY_IN(dly),
    .TARGET_REACHED_IN(tgt), .MOVE_EN_OUT(mv), .DIR_POS_OUT(dir),
    .HIGH_SPEED_OUT(hi), .BUSY_OUT(busy), .DRIVE_STATE_WORD_OUT(word));
  shs_motor_model u_motor (
    .clk_in(clk), .move_en_in(mv), .dir_pos_in(dir),
    .high_speed_in(hi), .load_in(load), .load_pos_in(ld_pos),
    .fault_in(flt), .pos_limit_out(pos_lim), .neg_limit_out(neg_lim),
    .home_sw_out(home_sw), .index_out(idx), .torque_out(trq),
    .target_out(tgt));
  // ----------------------------------------------------------------
  // Monitor, timeout and reporting
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (mv === 1'b1 && mv_d !== 1'b1 && !got_first) begin
      got_first = 1'b1;
      f_dir = dir;
      f_hi = hi;
    end
    if (mv === 1'b0 && mv_d === 1'b1) t_stop = cyc;
    mv_d = mv;
    if (cyc > 60000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic run(input int m, input int st, input logic [1:0] f,
                     input logic a, input int stop_at);
    int n;
    n = 0;
    @(negedge clk);
    load = 1'b1;
    ld_pos = st[15:0];
    meth = m[7:0];
    abs_enc = a;
    thr = 16'h0001 + 16'($random(seed) & 32'hfff);
    dly = 16'($random(seed) & 32'h3);
    @(negedge clk);
    load = 1'b0;
    got_first = 1'b0;
    cmd[CMD_HOME_START_BIT] = 1'b1;
    while (word[13:12] === 2'b00 && n < 4000 &&
           (stop_at == 0 || n < stop_at + 6)) begin
      @(negedge clk);
      n++;
      if (n == 8) meth = 8'($random(seed));
      if (n == 12) flt = f;
      if (n == stop_at) cmd[CMD_HOME_START_BIT] = 1'b0;
    end
    t_done = cyc;
  endtask
  task automatic release_cmd();
    @(negedge clk);
    cmd = '0;
    flt = 2'h0;
    abs_enc = 1'b0;
    repeat (6) @(negedge clk);
    check(word & 16'h3000, 16'h0000);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int m;
    int lo;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 18; i++) begin
      m = meths[i];
      run(m, starts[i], 2'h0, 1'b0, 0);
      lo = (m <= -3) ? 4 * int'(dly) : 0;
      check(word & 16'h3000, 16'h1000);
      check(16'(f_dir), 16'(fdirs[i]));
      check(16'(f_hi), 16'(m > -5));
      check({15'h0, trq != 16'h0}, {15'h0, m <= -5});
      if (m >= -2) check(16'(idx), 16'h0001);
      if (m >= 3) check(16'(home_sw), 16'(m == 4 || m == 6));
      check({15'h0, (t_done - t_stop) >= lo && (t_done - t_stop) <= lo + 8},
            16'h0001);
      release_cmd();
    end
    for (int i = 0; i < 6; i++) begin
      run(fm[i], 0, ff[i], i == 5, 0);
      check(word & 16'h3000, 16'h2000);
      check({15'h0, mv}, 16'h0000);
      release_cmd();
    end
    run(3, 0, 2'h0, 1'b0, 20);
    // Stopped axis reports target reached in bit 10
    check({word[15:1], mv}, 16'h0400);
    release_cmd();
    close_out();
  end
endmodule
bind shs_sequencer shs_seq_asserts u_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN),
  .DRIVE_COMMAND_WORD_IN(DRIVE_COMMAND_WORD_IN),
  .HOMING_METHOD_IN(HOMING_METHOD_IN), .ABS_ENCODER_IN(ABS_ENCODER_IN),
  .POS_LIMIT_IN(POS_LIMIT_IN), .NEG_LIMIT_IN(NEG_LIMIT_IN),
  .TARGET_REACHED_IN(TARGET_REACHED_IN), .MOVE_EN_OUT(MOVE_EN_OUT),
  .DIR_POS_OUT(DIR_POS_OUT), .BUSY_OUT(BUSY_OUT),
  .DRIVE_STATE_WORD_OUT(DRIVE_STATE_WORD_OUT));
